// >>> rtl/fan_pwm_regs.svh
// Purpose: Register offsets, fields, reset values and timing figures of the fan block.
// Assumes: Included by bare name from design files.
// Notes: Definitions only.
`ifndef FAN_PWM_REGS_SVH
`define FAN_PWM_REGS_SVH
`define ADDR_OUT_CFG 8'h4a
`define ADDR_SPIN_CFG 8'h4b
`define ADDR_DUTY 8'h4c
`define ADDR_FREQ 8'h4d
`define ADDR_LUT_HI 4'h5
`define RST_OUT_CFG 8'h20
`define RST_SPIN_CFG 8'h3f
`define RST_DUTY 6'h00
`define RST_FREQ 5'h17
`define RST_LUT_TEMP 7'h7f
`define RST_LUT_PWM 6'h3f
`define OC_MANUAL 5
`define OC_POL 4
`define OC_CLKSEL 3
`define OC_RSVD 2
`define SC_FAST 5
`define CLK_HZ 10000000
`define PWMCLK_FAST_HZ 360000
`define PWMCLK_SLOW_HZ 1400
`define SPIN_BASE_MS 50
`define LUT_ENTRIES 8
`endif

// >>> rtl/fan_pwm_pkg.sv
// Purpose: Shared types of the fan block.
// Assumes: Nothing beyond the register header.
// Notes: Types only.
package fan_pwm_pkg;
   typedef enum logic [0:0] {st_idle, st_spin} spin_state_t;
   typedef logic [7:0] reg_byte_t;
endpackage

// >>> rtl/tick_divider.sv
// Purpose: Divide the core clock into a one-cycle tick.
// Assumes: DIV of at least one.
// Notes: Used once per selectable PWM master clock.
`timescale 1ns/1ps
module tick_divider #(
   parameter int unsigned DIV = 28
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst,
   // Tick out.
   output logic tick
);
   logic [15:0] cnt;

   // Count up and pulse tick at wrap.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cnt <= 16'h0000;
         tick <= 1'b0;
      end else if (cnt == 16'(DIV - 1)) begin
         cnt <= 16'h0000;
         tick <= 1'b1;
      end else begin
         cnt <= cnt + 16'h0001;
         tick <= 1'b0;
      end
   end
endmodule

// >>> rtl/fan_pwm_config_spinup.sv
// Purpose: Fan PWM configuration, duty selection, spin-up boost and open-drain drive.
// Assumes: Register port and inputs synchronous to core_clk at 10 MHz.
// Notes: Reads return data one cycle after the read strobe.
// How it works
// - Bits 7:6 of both configuration registers always read zero.
// - Manual bit clear: duty comes from temperature table; duty and table read-only.
// - Manual bit set: writing the duty register sets the output duty directly.
// - Table writes are accepted only while the manual bit is set.
// - Polarity 0: pull low for off, release for on; polarity 1 inverts.
// - Clock select picks 360 kHz master clock at 0, 1.4 kHz at 1.
// - Two-bit tach method field selects one of four measurement methods.
// - With 360 kHz clock the tach method in effect is always 00.
// - Fast bit clear: spin-up uses programmed boost duty and duration.
// - Fast bit set: full duty until duration ends or tach reaches target.
// - Fast spin-up ignores boost duty field and drives full on.
// - Duration code 000 skips spin-up whatever the fast bit holds.
// - Boost duty 00 skips spin-up unless fast spin-up is enabled.
// - Boost duty 01 is 50%, 10 about 75%, 11 is 100%; reset 11.
// - Duration codes 001 to 111 give 0.05 s doubling to 3.2 s.
// - Duty register reads zero while spin-up runs.
// - Table mode outputs the duty of the highest-numbered entry whose threshold is exceeded.
`timescale 1ns/1ps
`include "fan_pwm_regs.svh"
module fan_pwm_config_spinup
   import fan_pwm_pkg::*;
#(
   parameter int unsigned SLOW_DIV = (`CLK_HZ + `PWMCLK_SLOW_HZ - 1) / `PWMCLK_SLOW_HZ,
   parameter int unsigned SPIN_BASE_CYC = `SPIN_BASE_MS * (`CLK_HZ / 1000)
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst,
   // Register port.
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Sensing.
   input wire logic [6:0] remote_temp,
   input wire logic tach_at_target,
   // Open-drain fan pin.
   input wire logic fan_pwm_i,
   output logic fan_pwm_o,
   output logic fan_pwm_oe,
   // Status.
   output logic [1:0] tach_method,
   output logic spinning
);
   localparam int unsigned FAST_DIV = (`CLK_HZ + `PWMCLK_FAST_HZ - 1) / `PWMCLK_FAST_HZ;

   reg_byte_t out_cfg;
   reg_byte_t spin_cfg;
   logic [5:0] duty_val;
   logic [4:0] freq_n;
   logic [6:0] lut_temp [`LUT_ENTRIES];
   logic [5:0] lut_pwm [`LUT_ENTRIES];
   logic [5:0] lut_duty;
   logic [5:0] cmd_duty;
   logic cmd_was_zero;
   spin_state_t state;
   logic [31:0] spin_cnt;
   logic [31:0] spin_len;
   logic skip_spin;
   logic start_spin;
   logic tick_fast;
   logic tick_slow;
   logic pwm_tick;
   logic [6:0] period;
   logic [6:0] pwm_cnt;
   logic [8:0] boost_ticks;
   logic [6:0] duty_ticks;
   logic pwm_on;
   logic manual;
   logic is_lut;
   logic [2:0] lut_idx;
   logic pin_seen;

   assign manual = out_cfg[`OC_MANUAL];
   assign is_lut = (reg_addr[7:4] == `ADDR_LUT_HI);
   assign lut_idx = reg_addr[3:1];

   // Master PWM clock sources.
   tick_divider #(.DIV(FAST_DIV)) u_fast (
      .core_clk(core_clk),
      .rst(rst),
      .tick(tick_fast)
   );
   tick_divider #(.DIV(SLOW_DIV)) u_slow (
      .core_clk(core_clk),
      .rst(rst),
      .tick(tick_slow)
   );

   assign pwm_tick = out_cfg[`OC_CLKSEL] ? tick_slow : tick_fast;

   // Configuration registers; upper bits never stored.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         out_cfg <= `RST_OUT_CFG;
         spin_cfg <= `RST_SPIN_CFG;
         freq_n <= `RST_FREQ;
      end else if (reg_wr) begin
         if (reg_addr == `ADDR_OUT_CFG) begin
            out_cfg <= {2'b00, reg_wdata[5:0]};
         end
         if (reg_addr == `ADDR_SPIN_CFG) begin
            spin_cfg <= {2'b00, reg_wdata[5:0]};
         end
         if (reg_addr == `ADDR_FREQ) begin
            freq_n <= reg_wdata[4:0];
         end
      end
   end

   // Lookup table storage, writable only in manual mode.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int i = 0; i < `LUT_ENTRIES; i++) begin
            lut_temp[i] <= `RST_LUT_TEMP;
            lut_pwm[i] <= `RST_LUT_PWM;
         end
      end else if (reg_wr && manual && is_lut) begin
         if (reg_addr[0]) begin
            lut_pwm[lut_idx] <= reg_wdata[5:0];
         end else begin
            lut_temp[lut_idx] <= reg_wdata[6:0];
         end
      end
   end

   always_comb begin
      lut_duty = 6'h00;
      for (int i = 0; i < `LUT_ENTRIES; i++) begin
         if (remote_temp > lut_temp[i]) begin
            lut_duty = lut_pwm[i];
         end
      end
   end

   // Duty value register: written by host in manual mode, else tracks the table.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         duty_val <= `RST_DUTY;
      end else if (!manual) begin
         duty_val <= lut_duty;
      end else if (reg_wr && reg_addr == `ADDR_DUTY) begin
         duty_val <= reg_wdata[5:0];
      end
   end

   assign cmd_duty = duty_val;

   assign skip_spin = (spin_cfg[2:0] == 3'b000) ||
                      (spin_cfg[4:3] == 2'b00 && !spin_cfg[`SC_FAST]);
   assign start_spin = cmd_was_zero && (cmd_duty != 6'h00) && !skip_spin;
   assign spin_len = 32'(SPIN_BASE_CYC) << (spin_cfg[2:0] - 3'd1);

   // Remember whether the commanded duty was zero.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cmd_was_zero <= 1'b1;
      end else begin
         cmd_was_zero <= (cmd_duty == 6'h00);
      end
   end

   // Spin-up sequencer; the spinning output is a flop kept in step with the state.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state <= st_idle;
         spinning <= 1'b0;
         spin_cnt <= 32'h0000_0000;
      end else begin
         case (state)
            st_idle: begin
               spin_cnt <= 32'h0000_0000;
               if (start_spin) begin
                  state <= st_spin;
                  spinning <= 1'b1;
               end
            end
            st_spin: begin
               spin_cnt <= spin_cnt + 32'h0000_0001;
               if (cmd_duty == 6'h00) begin
                  state <= st_idle;
                  spinning <= 1'b0;
               end else if (spin_cnt >= spin_len - 32'h0000_0001) begin
                  state <= st_idle;
                  spinning <= 1'b0;
               end else if (spin_cfg[`SC_FAST] && tach_at_target) begin
                  state <= st_idle;
                  spinning <= 1'b0;
               end
            end
            default: begin
               state <= st_idle;
               spinning <= 1'b0;
            end
         endcase
      end
   end

   // PWM period is 2n master ticks, n of zero treated as one.
   assign period = (freq_n == 5'h00) ? 7'h02 : {1'b0, freq_n, 1'b0};

   always_comb begin
      boost_ticks = {2'b00, period};
      if (!spin_cfg[`SC_FAST]) begin
         case (spin_cfg[4:3])
            2'b01: boost_ticks = {3'b000, period[6:1]};
            2'b10: boost_ticks = 9'((9'(period) * 9'h003 + 9'h003) >> 2);
            default: boost_ticks = {2'b00, period};
         endcase
      end
   end

   assign duty_ticks = spinning ? boost_ticks[6:0] : {1'b0, cmd_duty};

   // Master tick counter across one PWM period.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pwm_cnt <= 7'h00;
      end else if (pwm_tick) begin
         if (pwm_cnt >= period - 7'h01) begin
            pwm_cnt <= 7'h00;
         end else begin
            pwm_cnt <= pwm_cnt + 7'h01;
         end
      end
   end

   assign pwm_on = (pwm_cnt < duty_ticks);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         fan_pwm_oe <= 1'b1;
         fan_pwm_o <= 1'b0;
      end else begin
         fan_pwm_oe <= out_cfg[`OC_POL] ? pwm_on : !pwm_on;
         fan_pwm_o <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         tach_method <= 2'b00;
      end else begin
         tach_method <= out_cfg[`OC_CLKSEL] ? out_cfg[1:0] : 2'b00;
      end
   end

   // Keep a registered copy of the pin level; no register read returns it.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pin_seen <= 1'b0;
      end else begin
         pin_seen <= fan_pwm_i;
      end
   end

   // Read data, one cycle after the strobe; unmapped reads return zero.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         if (reg_addr == `ADDR_OUT_CFG) begin
            reg_rdata <= out_cfg;
         end else if (reg_addr == `ADDR_SPIN_CFG) begin
            reg_rdata <= spin_cfg;
         end else if (reg_addr == `ADDR_DUTY) begin
            reg_rdata <= spinning ? 8'h00 : {2'b00, duty_val};
         end else if (reg_addr == `ADDR_FREQ) begin
            reg_rdata <= {3'b000, freq_n};
         end else if (is_lut) begin
            reg_rdata <= reg_addr[0] ? {2'b00, lut_pwm[lut_idx]} : {1'b0, lut_temp[lut_idx]};
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end

   // Checks on the logic above.
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   sequence s_cfg_read;
      reg_rd && (reg_addr == `ADDR_OUT_CFG || reg_addr == `ADDR_SPIN_CFG);
   endsequence
   property p_upper_zero;
      s_cfg_read |=> reg_rdata[7:6] == 2'b00;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("config upper bits nonzero");

   property p_table_locked;
      (reg_wr && !manual && reg_addr == 8'h51) |=> $stable(lut_pwm[0]);
   endproperty
   a_table_locked: assert property (p_table_locked) else $error("table written in auto");

   property p_auto_duty;
      (!manual && !$past(manual) && $stable(remote_temp)) |=> duty_val == $past(lut_duty);
   endproperty
   a_auto_duty: assert property (p_auto_duty) else $error("duty not from table");

   property p_manual_write;
      (manual && reg_wr && reg_addr == `ADDR_DUTY) |=> duty_val == $past(reg_wdata[5:0]);
   endproperty
   a_manual_write: assert property (p_manual_write) else $error("manual duty lost");

   property p_polarity;
      1'b1 |=> fan_pwm_oe == ($past(out_cfg[`OC_POL]) ? $past(pwm_on) : !$past(pwm_on));
   endproperty
   a_polarity: assert property (p_polarity) else $error("pin drive polarity wrong");

   property p_tach_forced;
      !out_cfg[`OC_CLKSEL] |=> tach_method == 2'b00;
   endproperty
   a_tach_forced: assert property (p_tach_forced) else $error("tach method not 00");

   sequence s_rise_no_time;
      cmd_was_zero && cmd_duty != 6'h00 && spin_cfg[2:0] == 3'b000;
   endsequence
   property p_skip_time;
      (!spinning ##0 s_rise_no_time) |=> !spinning;
   endproperty
   a_skip_time: assert property (p_skip_time) else $error("spin-up not skipped");

   property p_read_zero;
      (spinning && reg_rd && reg_addr == `ADDR_DUTY) |=> reg_rdata == 8'h00;
   endproperty
   a_read_zero: assert property (p_read_zero) else $error("duty read nonzero in spin");

   property p_tach_end;
      (spinning && spin_cfg[`SC_FAST] && tach_at_target) |=> !spinning;
   endproperty
   a_tach_end: assert property (p_tach_end) else $error("fast spin-up not ended");

   property p_fast_full;
      (spinning && spin_cfg[`SC_FAST]) |-> duty_ticks == period;
   endproperty
   a_fast_full: assert property (p_fast_full) else $error("fast boost not full");
endmodule

// >>> tb/fan_model.sv
// Purpose: Behavioural fan with an open-drain PWM input and tach feedback.
// Assumes: The pin is pulled up; the bench gives the programmed polarity.
// Notes: Speed is a count of driven cycles; the fan stops at once when off.
`timescale 1ns/1ps
module fan_model #(
   parameter int TARGET_CYC = 30
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst,
   // Pin and polarity.
   input wire logic pin,
   input wire logic pol,
   // Tach status.
   output logic at_target
);
   int speed;
   logic on;
   // The fan runs on a released pin at polarity 0 and on a low pin at polarity 1.
   assign on = pol ? (pin == 1'b0) : (pin == 1'b1);
   // Speed builds while driven, so a slow fan reaches target late.
   always_ff @(posedge core_clk) begin
      if (rst || !on) begin
         speed <= 0;
      end else if (speed < TARGET_CYC) begin
         speed <= speed + 1;
      end
   end
   // Tach reports the target once enough on time has built up.
   assign at_target = (speed >= TARGET_CYC);
endmodule

// >>> tb/fan_pwm_config_spinup_tb.sv
// Purpose: Self-checking bench for fan configuration and spin-up.
// Assumes: Short divider and spin-up base counts.
// Notes: Inputs change at the falling edge; the pin is pulled up.
`timescale 1ns/1ps
module fan_pwm_config_spinup_tb;
   import fan_pwm_pkg::*;
   localparam int unsigned SPIN = 20;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic pol = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [6:0] remote_temp = 7'h00;
   logic [7:0] reg_rdata;
   logic fan_pwm_o, fan_pwm_oe, spinning, at_target, pin;
   logic [1:0] tach_method;
   int n_fail = 0;
   int n_compared = 0;
   logic [7:0] cfg_tab [6] = '{8'h38, 8'h01, 8'h21, 8'h19, 8'h1a, 8'h1b};
   int len_tab [6] = '{0, 0, SPIN, SPIN, 2 * SPIN, 4 * SPIN};

   // Clock of 100 ns period.
   always #50 core_clk = ~core_clk;
   // Open-drain wire with its pull-up.
   assign pin = fan_pwm_oe ? fan_pwm_o : 1'b1;

   fan_pwm_config_spinup #(.SLOW_DIV(8), .SPIN_BASE_CYC(SPIN)) u_dut (
      .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .remote_temp(remote_temp), .tach_at_target(at_target), .fan_pwm_i(pin),
      .fan_pwm_o(fan_pwm_o), .fan_pwm_oe(fan_pwm_oe), .tach_method(tach_method),
      .spinning(spinning));
   fan_model u_fan (.core_clk(core_clk), .rst(rst), .pin(pin), .pol(pol),
      .at_target(at_target));

   // Ends the run with the counts and the verdict.
   task test_done;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Compares one value and counts it.
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         n_fail++;
      end
   endtask
   task idle(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // One write strobe of one cycle.
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge core_clk);
      reg_wr = 1'b0;
   endtask
   // One read strobe; data is taken once it has landed.
   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge core_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge core_clk);
      reg_rd = 1'b0;
      @(negedge core_clk);
      chk({8'h00, reg_rdata}, {8'h00, exp});
   endtask
   // Starts a duty from zero and counts spin-up cycles; full drive is expected.
   task run_spin(input logic [7:0] cfg, output int n);
      wr(8'h4c, 8'h00);
      wr(8'h4b, cfg);
      idle(3);
      wr(8'h4c, 8'h3f);
      n = 0;
      for (int i = 0; i < 3000; i++) begin
         @(negedge core_clk);
         if (spinning === 1'b1) begin
            n++;
            if (n > 2) chk(16'(fan_pwm_oe), 16'h0);
         end else if (n > 0 || i > 8) begin
            break;
         end
      end
      if (spinning !== 1'b0) begin
         n_fail++;
         test_done();
      end
   endtask
   // Counts pin changes over a fixed window.
   task edges(output int e);
      logic last;
      e = 0;
      last = fan_pwm_oe;
      repeat (112) begin
         @(negedge core_clk);
         if (fan_pwm_oe !== last) e++;
         last = fan_pwm_oe;
      end
   endtask
   // Counts cycles with the pin released, which is fan on at polarity 0.
   task ontime(output int e);
      e = 0;
      repeat (112) begin
         @(negedge core_clk);
         if (fan_pwm_oe === 1'b0) e++;
      end
   endtask

   // Main sequence.
   initial begin
      int n;
      idle(12);
      rst = 1'b0;
      rd(8'h4a, 8'h20);
      rd(8'h4b, 8'h3f);
      rd(8'h4e, 8'h00);
      $display("reset test done");
      wr(8'h4a, 8'he3);
      rd(8'h4a, 8'h23);
      chk(16'(tach_method), 16'h0);
      wr(8'h4b, 8'hff);
      rd(8'h4b, 8'h3f);
      for (int m = 0; m < 4; m++) begin
         wr(8'h4a, 8'h28 | 8'(m));
         idle(2);
         chk(16'(tach_method), 16'(m));
      end
      $display("field test done");
      wr(8'h4b, 8'h38);
      wr(8'h4a, 8'h20);
      wr(8'h4c, 8'h00);
      idle(3);
      chk(16'(fan_pwm_oe), 16'h1);
      pol = 1'b1;
      wr(8'h4a, 8'h30);
      idle(3);
      chk(16'(fan_pwm_oe), 16'h0);
      wr(8'h4c, 8'h3f);
      idle(3);
      chk(16'(fan_pwm_oe), 16'h1);
      chk(16'(spinning), 16'h0);
      chk(16'(fan_pwm_o), 16'h0);
      pol = 1'b0;
      wr(8'h4a, 8'h20);
      idle(3);
      chk(16'(fan_pwm_oe), 16'h0);
      $display("polarity test done");
      for (int k = 0; k < 6; k++) begin
         run_spin(cfg_tab[k], n);
         chk(16'(n), 16'(len_tab[k]));
      end
      run_spin(8'h27, n);
      chk(16'(n >= 30 && n <= 34), 16'h1);
      wr(8'h4b, 8'h1f);
      wr(8'h4c, 8'h00);
      idle(3);
      wr(8'h4c, 8'h3f);
      idle(3);
      rd(8'h4c, 8'h00);
      wr(8'h4c, 8'h00);
      idle(3);
      chk(16'(spinning), 16'h0);
      wr(8'h4b, 8'h00);
      wr(8'h4c, 8'h15);
      rd(8'h4c, 8'h15);
      $display("spin-up test done");
      wr(8'h4d, 8'h01);
      wr(8'h4c, 8'h01);
      edges(n);
      chk(16'(n >= 3 && n <= 5), 16'h1);
      wr(8'h4a, 8'h28);
      edges(n);
      chk(16'(n >= 13 && n <= 15), 16'h1);
      wr(8'h4d, 8'h02);
      wr(8'h4b, 8'h0c);
      wr(8'h4c, 8'h00);
      idle(3);
      wr(8'h4c, 8'h3f);
      ontime(n);
      chk(16'(n >= 46 && n <= 66), 16'h1);
      wr(8'h4c, 8'h00);
      wr(8'h4b, 8'h14);
      idle(3);
      wr(8'h4c, 8'h3f);
      ontime(n);
      chk(16'(n >= 70 && n <= 90), 16'h1);
      wr(8'h4b, 8'h00);
      wr(8'h4c, 8'h00);
      idle(3);
      chk(16'(spinning), 16'h0);
      $display("clock test done");
      wr(8'h4a, 8'h20);
      wr(8'h50, 8'h10);
      wr(8'h51, 8'h0a);
      remote_temp = 7'h11;
      wr(8'h4a, 8'h00);
      idle(3);
      rd(8'h4c, 8'h0a);
      wr(8'h51, 8'h20);
      wr(8'h4c, 8'h30);
      rd(8'h4c, 8'h0a);
      rd(8'h51, 8'h0a);
      remote_temp = 7'h10;
      idle(3);
      rd(8'h4c, 8'h00);
      $display("table test done");
      test_done();
   end
endmodule
